// ==== hw/orb_rate_cfg.sv ====
`timescale 1ns/1ps
// Functional notes
// - divisor bits 23:0 writable, 31:24 read zero
// - sample clock equals master clock over divisor
// - master clock nominal 45 MHz, only option
// - config bit 16 set means eight inputs
// - config bit 17 set means no outputs
// - config bits 31:20 always read zero
// - buffer serves block and demand DMA
// - burst starts from either trigger bit
// - no interrupt; status read by software
module orb_rate_cfg
  import orb_pkg::*;
#(
  parameter logic [11:0] FW_REV = 12'h001  // Arbitrary revision value
) (
  input  wire  logic                  mclk,
  input  wire  logic                  rst,
  input  wire  orb_pkg::orb_lb_req_s  lb_req,
  output logic [31:0]                 lb_rdata,
  output logic                        lb_rd_ack,
  output logic                        lb_ready,
  output logic                        dma_dreq,
  input  wire  logic                  strap_in8_ch,
  input  wire  logic                  strap_no_ao,
  input  wire  logic                  out_ops_burst_trig,
  input  wire  logic                  board_ctl_burst_trig,
  output logic                        burst_start,
  output logic                        out_clk_strobe,
  output orb_pkg::orb_word_s          out_word,
  output logic                        out_valid,
  input  wire  logic                  out_ready
);
  import orb_pkg::*;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  wire logic wr_div   = lb_req.wr & hit(lb_req.addr, ORB_OFF_DIV);
  wire logic wr_buf   = lb_req.wr & hit(lb_req.addr, ORB_OFF_OUT_BUF);
  wire logic rd_div   = lb_req.rd & hit(lb_req.addr, ORB_OFF_DIV);
  wire logic rd_cfg   = lb_req.rd & hit(lb_req.addr, ORB_OFF_ASSY);

  logic [23:0]  div_ff;
  logic [23:0]  cnt_ff;
  logic         strobe_ff;
  logic [1:0]   s1_ff;
  logic [1:0]   s2_ff;
  logic [31:0]  rdata_ff;
  logic         rd_ack_ff;
  logic         trig_prev_ff;
  logic         burst_ff;
  orb_word_s    mem_ff [ORB_BUF_DEPTH];
  logic [1:0]   bcnt_ff;
  logic         ready_ff;
  logic         valid_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Divisor register, low 24 bits only
  always_ff @(posedge mclk) begin
    if (rst) begin
      div_ff <= ORB_DIV_RST;
    end else if (wr_div) begin
      div_ff <= lb_req.wdata[ORB_DIV_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rate counter; zero or one divisor gives a strobe every cycle
  wire logic [23:0] last_cnt = (div_ff == 24'h000000) ? 24'h000000 : div_ff - 24'h000001;
  wire logic        at_last  = (cnt_ff >= last_cnt);
  wire logic [23:0] nxt_cnt  = (wr_div | at_last) ? 24'h000000 : cnt_ff + 24'h000001;
  wire logic        nxt_strobe = at_last & ~wr_div;

  // Counter restarts on a divisor write so a new rate starts clean
  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_ff    <= 24'h000000;
      strobe_ff <= 1'b0;
    end else begin
      cnt_ff    <= nxt_cnt;
      strobe_ff <= nxt_strobe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strap synchronisers; straps come from pins
  always_ff @(posedge mclk) begin
    if (rst) begin
      s1_ff <= 2'h0;
      s2_ff <= 2'h0;
    end else begin
      s1_ff <= {strap_no_ao, strap_in8_ch};
      s2_ff <= s1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped and the write-only buffer read zero
  logic [31:0] cfg_word;
  always_comb begin
    cfg_word = 32'h00000000;
    cfg_word[11:0] = FW_REV;
    cfg_word[ORB_CFG_IN8_BIT]  = s2_ff[0];
    cfg_word[ORB_CFG_NOAO_BIT] = s2_ff[1];
    cfg_word[ORB_CFG_MCLK_HI:ORB_CFG_MCLK_LO] = ORB_MCLK_45M;
  end
  wire logic [31:0] nxt_rdata = rd_div ? {8'h00, div_ff} :
                                rd_cfg ? cfg_word : 32'h00000000;

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_ff  <= 32'h00000000;
      rd_ack_ff <= 1'b0;
    end else begin
      rdata_ff  <= nxt_rdata;
      rd_ack_ff <= lb_req.rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Burst trigger: rising edge of the OR of the two duplicated trigger bits
  wire logic trig_any = out_ops_burst_trig | board_ctl_burst_trig;
  always_ff @(posedge mclk) begin
    if (rst) begin
      trig_prev_ff <= 1'b0;
      burst_ff     <= 1'b0;
    end else begin
      trig_prev_ff <= trig_any;
      burst_ff     <= trig_any & ~trig_prev_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry output buffer at one fixed address
  // A write while not ready is dropped; the bridge must honour lb_ready
  wire orb_word_s  win  = '{eof: lb_req.wdata[ORB_EOF_BIT], data: lb_req.wdata[15:0]};
  wire logic       push = wr_buf & ready_ff;
  wire logic       pop  = valid_ff & out_ready;
  wire logic [1:0] nxt_bcnt = bcnt_ff + {1'b0, push} - {1'b0, pop};
  wire orb_word_s  nxt_m0 = pop ? ((bcnt_ff == ORB_BUF_FULL) ? mem_ff[1] : win)
                                : ((bcnt_ff == 2'h0) ? win : mem_ff[0]);
  wire orb_word_s  nxt_m1 = push ? win : mem_ff[1];

  always_ff @(posedge mclk) begin
    if (rst) begin
      bcnt_ff  <= 2'h0;
      ready_ff <= 1'b1;
      valid_ff <= 1'b0;
    end else begin
      bcnt_ff  <= nxt_bcnt;
      ready_ff <= (nxt_bcnt != ORB_BUF_FULL);
      valid_ff <= (nxt_bcnt != 2'h0);
    end
  end

  // Data flops need no reset; valid guards them
  always_ff @(posedge mclk) begin
    mem_ff[0] <= nxt_m0;
    mem_ff[1] <= nxt_m1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; no interrupt line, status is polled
  assign lb_rdata       = rdata_ff;
  assign lb_rd_ack      = rd_ack_ff;
  assign lb_ready       = ready_ff;
  assign dma_dreq       = ready_ff;
  assign burst_start    = burst_ff;
  assign out_clk_strobe = strobe_ff;
  assign out_word       = mem_ff[0];
  assign out_valid      = valid_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [23:0] gap_ff;
  logic        gap_ok_ff;
  always_ff @(posedge mclk) begin
    if (rst | wr_div) begin
      gap_ff    <= 24'h000000;
      gap_ok_ff <= 1'b0;
    end else if (strobe_ff) begin
      gap_ff    <= 24'h000001;
      gap_ok_ff <= 1'b1;
    end else begin
      gap_ff    <= gap_ff + 24'h000001;
    end
  end
  wire logic [23:0] eff_div = (div_ff == 24'h000000) ? 24'h000001 : div_ff;

  sequence s_trig_rise;
    trig_any && !trig_prev_ff;
  endsequence
  sequence s_one_pulse;
    burst_ff ##1 !burst_ff;
  endsequence

  a_div_read_zero: assert property (@(posedge mclk) disable iff (rst)
    rd_div |=> rd_ack_ff && rdata_ff[31:24] == 8'h00 && rdata_ff[23:0] == $past(div_ff))
    else $error("divisor readback wrong");
  a_div_write_keep: assert property (@(posedge mclk) disable iff (rst)
    wr_div |=> div_ff == $past(lb_req.wdata[23:0]))
    else $error("divisor write lost");
  a_strobe_period: assert property (@(posedge mclk) disable iff (rst)
    strobe_ff && gap_ok_ff && !$past(wr_div) |-> gap_ff == eff_div)
    else $error("strobe spacing not divisor");
  a_strobe_single: assert property (@(posedge mclk) disable iff (rst)
    strobe_ff && div_ff > 24'h000001 && !wr_div |=> !strobe_ff)
    else $error("strobe longer than one cycle");
  a_cfg_fields: assert property (@(posedge mclk) disable iff (rst)
    rd_cfg |=> rdata_ff[16] == $past(s2_ff[0]) && rdata_ff[17] == $past(s2_ff[1]))
    else $error("channel count fields wrong");
  a_cfg_reserved: assert property (@(posedge mclk) disable iff (rst)
    rd_cfg |=> rdata_ff[31:20] == 12'h000 && rdata_ff[19:18] == ORB_MCLK_45M)
    else $error("config reserved bits not zero");
  a_burst_pulse: assert property (@(posedge mclk) disable iff (rst)
    s_trig_rise |=> s_one_pulse)
    else $error("burst start not one pulse");
  a_buf_stall: assert property (@(posedge mclk) disable iff (rst)
    bcnt_ff == ORB_BUF_FULL |-> !lb_ready && !dma_dreq)
    else $error("full buffer still ready");
  a_buf_first_word: assert property (@(posedge mclk) disable iff (rst)
    push && bcnt_ff == 2'h0 |=> out_valid && out_word == $past(win))
    else $error("buffer head word wrong");
endmodule

// ==== hw/orb_pkg.sv ====
package orb_pkg;
  // Local bus byte offsets
  localparam logic [7:0]  ORB_OFF_ASSY    = 8'h34;
  localparam logic [7:0]  ORB_OFF_OUT_BUF = 8'h48;
  localparam logic [7:0]  ORB_OFF_DIV     = 8'h4C;

  // Divisor field
  localparam int          ORB_DIV_W       = 24;
  localparam logic [23:0] ORB_DIV_RST     = 24'h00007E;

  // Assembly options layout
  localparam int          ORB_CFG_IN8_BIT = 16;
  localparam int          ORB_CFG_NOAO_BIT = 17;
  localparam int          ORB_CFG_MCLK_LO = 18;
  localparam int          ORB_CFG_MCLK_HI = 19;
  localparam logic [1:0]  ORB_MCLK_45M    = 2'h0;
  localparam int          ORB_MCLK_HZ     = 45000000;

  // Output buffer word layout
  localparam int          ORB_EOF_BIT     = 16;
  localparam int          ORB_BUF_DEPTH   = 2;
  localparam logic [1:0]  ORB_BUF_FULL    = 2'h2;

  typedef struct packed {
    logic        eof;
    logic [15:0] data;
  } orb_word_s;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } orb_lb_req_s;
endpackage

// ==== verification/orb_host_dma.sv ====
`timescale 1ns/1ps
// Bridge model: register cycles and DMA into the fixed buffer port
module orb_host_dma
  import orb_pkg::*;
(
  input  wire logic                 mclk,
  output orb_pkg::orb_lb_req_s      lb_req,
  input  wire logic [31:0]          lb_rdata,
  input  wire logic                 lb_rd_ack,
  input  wire logic                 dma_dreq
);
  int timeouts = 0;
  initial lb_req = '0;
  // One-cycle write; demand mode waits for the board request first
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input bit dm);
    bit go;
    go = 1'b0;
    for (int k = 0; k < 60 && !go; k++) begin
      @(posedge mclk);
      #1 go = !dm || dma_dreq === 1'b1;
    end
    if (!go) timeouts++;
    lb_req = '{1'b1, 1'b0, a, d};
    @(posedge mclk);
    #1 lb_req = '{1'b0, 1'b0, ~a, ~d}; // Stale bus inverted, not kept
  endtask
  // Read strobe, then bounded wait for the one-cycle answer
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    bit got;
    got = 1'b0;
    d   = 32'h0;
    @(posedge mclk);
    #1 lb_req = '{1'b0, 1'b1, a, 32'h0};
    @(posedge mclk);
    #1 lb_req = '{1'b0, 1'b0, ~a, 32'hFFFFFFFF};
    for (int k = 0; k < 4 && !got; k++) begin
      if (lb_rd_ack === 1'b1) begin
        d   = lb_rdata;
        got = 1'b1;
      end else begin
        @(posedge mclk);
        #1;
      end
    end
    if (!got) timeouts++;
  endtask
  // Host memory to local bus, constant address, eof on the last word
  task automatic dma(input int n, input bit dm);
    for (int i = 0; i < n; i++) begin
      wr(ORB_OFF_OUT_BUF, {15'h0, i == n - 1, 16'hA5A0 + 16'(i)}, dm);
    end
  endtask
endmodule

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import orb_pkg::*;
  localparam logic [11:0] FW = 12'h5A3;  // Arbitrary revision value
  logic mclk, rst, in8, noao, trg_ops, trg_ctl, bst, stb, ov, ordy, lrdy, dreq, ack;
  logic [31:0] rdat, rv;
  orb_lb_req_s req;
  orb_word_s   ow;
  int          err_total;
  int          checked;
  int          dv[2] = '{2, 5};
  orb_rate_cfg #(.FW_REV(FW)) orb_rate_cfg_i (.mclk(mclk), .rst(rst), .lb_req(req),
    .lb_rdata(rdat), .lb_rd_ack(ack), .lb_ready(lrdy), .dma_dreq(dreq),
    .strap_in8_ch(in8), .strap_no_ao(noao), .out_ops_burst_trig(trg_ops),
    .board_ctl_burst_trig(trg_ctl),
    .burst_start(bst), .out_clk_strobe(stb), .out_word(ow), .out_valid(ov),
    .out_ready(ordy));
  orb_host_dma orb_host_dma_i (.mclk(mclk), .lb_req(req), .lb_rdata(rdat),
    .lb_rd_ack(ack), .dma_dreq(dreq));
  ////////////////////////////////////////////////////////////////////////////////
  // 40 MHz clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    #500000;
    err_total++;
    give_verdict;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Pop words on accepted edges; sent words fix the eof position
  task automatic drain(input int n, input int sent);
    int got;
    got = 0;
    for (int k = 0; k < 80 && got < n; k++) begin
      @(posedge mclk);
      if (ov === 1'b1 && ordy === 1'b1) begin
        chk(32'(ow), {15'h0, got == sent - 1, 16'hA5A0 + 16'(got)});
        got++;
      end
    end
    chk(32'(got), 32'(n));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst, in8, noao, trg_ops, trg_ctl, ordy} = 6'h20;
    repeat (12) @(posedge mclk);
    #1 rst = 1'b0;
    orb_host_dma_i.rd(ORB_OFF_DIV, rv);
    chk(rv, 32'h0000007E);
    orb_host_dma_i.wr(ORB_OFF_DIV, 32'hFFFFFFFF, 1'b0);
    orb_host_dma_i.wr(8'h50, 32'h00000003, 1'b0);
    orb_host_dma_i.rd(ORB_OFF_DIV, rv);
    chk(rv, 32'h00FFFFFF);
    orb_host_dma_i.rd(8'h50, rv);
    chk(rv, 32'h0);
    orb_host_dma_i.rd(ORB_OFF_OUT_BUF, rv);
    chk(rv, 32'h0);
    // Strobe once per divisor count, restarted by the write
    foreach (dv[j]) begin
      orb_host_dma_i.wr(ORB_OFF_DIV, dv[j], 1'b0);
      for (int i = 1; i <= 2 * dv[j]; i++) begin
        @(posedge mclk);
        #1 chk(stb, (i % dv[j]) == 0);
      end
    end
    for (int s = 0; s < 4; s++) begin
      {noao, in8} = 2'(s);
      repeat (4) @(posedge mclk);
      orb_host_dma_i.rd(ORB_OFF_ASSY, rv);
      chk(rv, {12'h0, 2'h0, noao, in8, 4'h0, FW});
    end
    // Either trigger starts one burst; a held level does not repeat it
    for (int t = 0; t < 2; t++) begin
      @(posedge mclk);
      #1 {trg_ops, trg_ctl} = t ? 2'h1 : 2'h2;
      @(posedge mclk);
      #1 chk(bst, 1);
      @(posedge mclk);
      #1 chk(bst, 0);
      {trg_ops, trg_ctl} = 2'h0;
    end
    // Block mode into a stalled buffer: third word refused
    orb_host_dma_i.dma(3, 1'b0);
    #1 chk(lrdy, 0);
    ordy = 1'b1;
    drain(2, 3);
    @(posedge mclk);
    #1 chk(ov, 0);
    // Demand mode: request drops while stalled, no word lost
    ordy = 1'b0;
    fork
      orb_host_dma_i.dma(4, 1'b1);
      begin
        repeat (14) @(posedge mclk);
        #1 chk(dreq, 0);
        ordy = 1'b1;
        drain(4, 4);
      end
    join
    chk(32'(orb_host_dma_i.timeouts), 32'h0);
    give_verdict;
  end
endmodule
